// *** hdl/dhc_host_port.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - parallel data lines used only in parallel mode
// - recovery input idles serial controller, serial mode
// - recovery keeps all register contents
// - three-wire reads leave on serial out pin
// - two-wire reads share the serial data pin
// - chip select high ignores serial activity
// - mode pin low serial, high parallel
// - hardware reset high restores all defaults
// - profile pins sampled on sync clock
// - update rising edge copies buffers to active
// - sync clock is core clock over eight
// - each profile holds tuning and phase words
// - tuning word is thirty-two bits wide
module dhc_host_port (
  // clock and resets
  input  wire logic                         clk_sys_i,
  input  wire logic                         reset_n_i,
  input  wire logic                         hw_reset_i,
  // port mode
  input  wire logic                         port_mode_select_i,
  input  wire logic                         serial_3wire_i,
  // shared strobes
  input  wire logic                         wr_n_sclk_i,
  input  wire logic                         rd_n_cs_n_i,
  // parallel bus
  input  wire logic [dhc_pkg::ADDR_W-1:0]   register_select_lines_i,
  input  wire logic [dhc_pkg::DATA_W-1:0]   parallel_data_lines_i,
  output logic      [dhc_pkg::DATA_W-1:0]   parallel_data_lines_o,
  output logic                              parallel_data_lines_oe_o,
  // serial port
  input  wire logic                         port_recovery_input_i,
  input  wire logic                         serial_data_i,
  output logic                              serial_data_o,
  output logic                              serial_data_oe_o,
  output logic                              serial_out_pin_o,
  output logic                              serial_out_pin_oe_o,
  // profile and update
  input  wire logic [dhc_pkg::PROF_W-1:0]   profile_select_inputs_i,
  input  wire logic                         update_strobe_i,
  output logic                              sync_clock_out_o,
  // synthesizer core side
  output dhc_pkg::dhc_prof_t                profile_o
);
  import dhc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // address of one byte of a profile
  function automatic logic [ADDR_W-1:0] prof_addr(input logic [PROF_W-1:0] p,
                                                  input logic [ADDR_W-1:0] ofs);
    logic [ADDR_W-1:0] base;
    base      = PROF_BASE + ADDR_W'(PROF_STRIDE * ADDR_W'(p));
    prof_addr = base + ofs;
  endfunction : prof_addr

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [DATA_W-1:0]     buf_q [NUM_REGS];
  logic [DATA_W-1:0]     act_q [NUM_REGS];
  logic                  sclk_prev_q;
  logic                  wr_prev_q;
  dhc_ser_state_t        st_q;
  dhc_ser_state_t        st_d;
  logic [2:0]            cnt_q;
  logic [2:0]            cnt_d;
  logic [DATA_W-1:0]     sin_q;
  logic [DATA_W-1:0]     sin_d;
  logic [DATA_W-1:0]     sout_q;
  logic [DATA_W-1:0]     sout_d;
  logic [ADDR_W-1:0]     addr_q;
  logic [ADDR_W-1:0]     addr_d;
  logic                  ser_wr;
  logic                  sdo_q;
  logic                  sdio_oe_q;
  logic                  sdo_oe_q;
  dhc_drive_t            pdrv_q;
  logic [SYNC_CNT_W-1:0] sync_cnt_q;
  logic                  sync_q;
  logic [PROF_W-1:0]     prof_q;
  logic                  upd_prev_q;
  dhc_prof_t             prof_out_q;

  ////////////////////////////////////////////////////////////////////////////
  // mode and strobe decode
  // reset high
  wire rst       = !reset_n_i || hw_reset_i;
  wire par_mode  = port_mode_select_i;
  wire ser_mode  = !port_mode_select_i;
  wire ser_rst   = rst || (ser_mode && port_recovery_input_i);
  wire ser_sel   = ser_mode && !rd_n_cs_n_i;
  wire sclk_rise = ser_sel && wr_n_sclk_i && !sclk_prev_q;
  wire sclk_fall = ser_sel && !wr_n_sclk_i && sclk_prev_q;
  wire par_wr    = par_mode && wr_n_sclk_i && !wr_prev_q;
  wire par_rd    = par_mode && !rd_n_cs_n_i;

  // buffer write port, shared by both ports
  // register address
  wire                    buf_we    = par_wr || ser_wr;
  wire [ADDR_W-1:0]       buf_waddr = par_wr ? register_select_lines_i : addr_q;
  wire [DATA_W-1:0]       buf_wdata = par_wr ? parallel_data_lines_i : sin_d;
  wire [DATA_W-1:0]       par_rdata = buf_q[register_select_lines_i];

  ////////////////////////////////////////////////////////////////////////////
  // strobe history
  always_ff @(posedge clk_sys_i)
  begin
    if (rst)
    begin
      sclk_prev_q <= 1'b1; // shift clock idles high, no false edge
      wr_prev_q   <= 1'b1;
    end
    else
    begin
      sclk_prev_q <= wr_n_sclk_i;
      wr_prev_q   <= wr_n_sclk_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial controller next state
  always_comb
  begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    sin_d  = sin_q;
    sout_d = sout_q;
    addr_d = addr_q;
    ser_wr = 1'b0;
    if (!ser_sel)
    begin
      st_d  = DHC_SER_IDLE;
      cnt_d = 3'h0;
    end
    else
    begin
      case (st_q)
        DHC_SER_IDLE:
        begin
          st_d  = DHC_SER_INSTR;
          cnt_d = 3'h0;
        end
        DHC_SER_INSTR:
        begin
          if (sclk_rise)
          begin
            sin_d = {sin_q[DATA_W-2:0], serial_data_i};
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == SER_LAST_BIT)
            begin
              addr_d = sin_d[ADDR_W-1:0];
              cnt_d  = 3'h0;
              if (sin_d[SER_RD_BIT])
              begin
                st_d   = DHC_SER_RDATA;
                sout_d = buf_q[sin_d[ADDR_W-1:0]];
              end
              else
              begin
                st_d = DHC_SER_WDATA;
              end
            end
          end
        end
        DHC_SER_WDATA:
        begin
          if (sclk_rise)
          begin
            sin_d = {sin_q[DATA_W-2:0], serial_data_i};
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == SER_LAST_BIT)
            begin
              ser_wr = 1'b1;
              st_d   = DHC_SER_INSTR;
              cnt_d  = 3'h0;
            end
          end
        end
        DHC_SER_RDATA:
        begin
          // next bit goes out on the falling shift clock
          if (sclk_fall && cnt_q != 3'h0)
          begin
            sout_d = {sout_q[DATA_W-2:0], 1'b0};
          end
          if (sclk_rise)
          begin
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == SER_LAST_BIT)
            begin
              st_d  = DHC_SER_INSTR;
              cnt_d = 3'h0;
            end
          end
        end
        default:
        begin
          st_d = DHC_SER_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial controller registers
  // controller only
  always_ff @(posedge clk_sys_i)
  begin
    if (ser_rst)
    begin
      st_q   <= DHC_SER_IDLE;
      cnt_q  <= 3'h0;
      sin_q  <= 8'h00;
      sout_q <= 8'h00;
      addr_q <= 6'h00;
    end
    else
    begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      sin_q  <= sin_d;
      sout_q <= sout_d;
      addr_q <= addr_d;
    end
  end

  // serial pin drivers
  // two-wire data pin and three-wire out pin
  always_ff @(posedge clk_sys_i)
  begin
    if (ser_rst)
    begin
      sdo_q     <= 1'b0;
      sdio_oe_q <= 1'b0;
      sdo_oe_q  <= 1'b0;
    end
    else
    begin
      sdo_q     <= sout_d[DATA_W-1];
      sdio_oe_q <= (st_d == DHC_SER_RDATA) && !serial_3wire_i;
      sdo_oe_q  <= (st_d == DHC_SER_RDATA) && serial_3wire_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffer registers
  // recovery untouched
  always_ff @(posedge clk_sys_i)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        buf_q[i] <= REG_RESET;
      end
    end
    else if (buf_we)
    begin
      buf_q[buf_waddr] <= buf_wdata;
    end
  end

  // parallel read drive
  // parallel only
  always_ff @(posedge clk_sys_i)
  begin
    if (rst)
    begin
      pdrv_q <= '0;
    end
    else
    begin
      pdrv_q.data <= par_rdata;
      pdrv_q.oe   <= par_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sync clock divider
  // divide by eight
  wire sync_en = (sync_cnt_q == SYNC_RISE_CNT);

  always_ff @(posedge clk_sys_i)
  begin
    if (rst)
    begin
      sync_cnt_q <= '0;
      sync_q     <= 1'b0;
    end
    else
    begin
      sync_cnt_q <= sync_cnt_q + 3'h1;
      sync_q     <= (sync_cnt_q + 3'h1) >= 3'(SYNC_DIV / 2);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // profile and update sampling
  // update edge
  wire upd_fire = sync_en && update_strobe_i && !upd_prev_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst)
    begin
      prof_q     <= '0;
      upd_prev_q <= 1'b0;
    end
    else if (sync_en)
    begin
      prof_q     <= profile_select_inputs_i;
      upd_prev_q <= update_strobe_i;
    end
  end

  // active registers
  // buffer transfer
  always_ff @(posedge clk_sys_i)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        act_q[i] <= REG_RESET;
      end
    end
    else if (upd_fire)
    begin
      act_q <= buf_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // selected profile words
  // per-profile words
  wire [TW_W-1:0] tw_sel = {act_q[prof_addr(prof_q, TW_OFS + 6'h03)],
                            act_q[prof_addr(prof_q, TW_OFS + 6'h02)],
                            act_q[prof_addr(prof_q, TW_OFS + 6'h01)],
                            act_q[prof_addr(prof_q, TW_OFS)]};
  wire [15:0]     ph_raw = {act_q[prof_addr(prof_q, PH_OFS + 6'h01)],
                            act_q[prof_addr(prof_q, PH_OFS)]};

  always_ff @(posedge clk_sys_i)
  begin
    if (rst)
    begin
      prof_out_q <= '0;
    end
    else
    begin
      prof_out_q.tuning <= tw_sel;
      prof_out_q.phase  <= ph_raw[PH_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign parallel_data_lines_o    = pdrv_q.data;
  assign parallel_data_lines_oe_o = pdrv_q.oe;
  assign serial_data_o            = sdo_q;
  assign serial_data_oe_o         = sdio_oe_q;
  assign serial_out_pin_o         = sdo_q;
  assign serial_out_pin_oe_o      = sdo_oe_q;
  assign sync_clock_out_o         = sync_q;
  assign profile_o                = prof_out_q;

endmodule : dhc_host_port

// *** hdl/dhc_pkg.sv ***
package dhc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int ADDR_W   = 6;
  localparam int DATA_W   = 8;
  localparam int NUM_REGS = 64;
  localparam int TW_W     = 32;
  localparam int PH_W     = 14;
  localparam int PROF_W   = 2;

  ////////////////////////////////////////////////////////////////////////////
  // profile layout in the byte register space, least significant byte first
  localparam logic [ADDR_W-1:0] PROF_BASE   = 6'h0a;
  localparam logic [ADDR_W-1:0] PROF_STRIDE = 6'h06;
  localparam logic [ADDR_W-1:0] TW_OFS      = 6'h00;
  localparam logic [ADDR_W-1:0] PH_OFS      = 6'h04;

  // value of every register after hardware reset
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // sync clock divider: one eighth of the core clock
  localparam int                SYNC_DIV      = 8;
  localparam int                SYNC_CNT_W    = 3;
  localparam logic [SYNC_CNT_W-1:0] SYNC_RISE_CNT = 3'h3;

  ////////////////////////////////////////////////////////////////////////////
  // serial frame: instruction byte then one data byte, msb first
  localparam logic [2:0] SER_LAST_BIT = 3'h7;
  localparam int         SER_RD_BIT   = 7;

  typedef enum logic [1:0] {
    DHC_SER_IDLE  = 2'b00,
    DHC_SER_INSTR = 2'b01,
    DHC_SER_WDATA = 2'b10,
    DHC_SER_RDATA = 2'b11
  } dhc_ser_state_t;

  // active profile values handed to the synthesizer core
  typedef struct packed {
    logic [TW_W-1:0] tuning;
    logic [PH_W-1:0] phase;
  } dhc_prof_t;

  // byte driven back onto the parallel data lines
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              oe;
  } dhc_drive_t;

endpackage : dhc_pkg

// *** tb/dhc_host_model.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// host programming the port, parallel or serial
module dhc_host_model (
  // clock and wiring
  input  wire logic       clk_sys_i,
  input  wire logic       three_i,
  // host pins
  output logic            mode_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic            rec_o,
  output logic            sd_o,
  output logic [5:0]      addr_o,
  output logic [7:0]      dat_o,
  // device pins
  input  wire logic [7:0] pd_i,
  input  wire logic       pd_oe_i,
  input  wire logic       sdo_i,
  input  wire logic       sdio_i
);
  // idle in parallel mode, strobes high
  initial {mode_o, wr_o, rd_o, rec_o, sd_o, addr_o, dat_o} = 19'h70000;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : cyc
  task automatic pwr(input logic [5:0] a, input logic [7:0] d);
    {mode_o, wr_o, addr_o, dat_o} = {2'b10, a, d};
    cyc(1);
    wr_o = 1'b1;
    cyc(1);
  endtask : pwr
  task automatic prd(input logic [5:0] a, output logic [7:0] d);
    {mode_o, rd_o, addr_o, dat_o} = {2'b10, a, ~dat_o};
    cyc(2);
    d = pd_oe_i ? pd_i : 8'hxx;
    rd_o = 1'b1;
    cyc(2);
  endtask : prd
  // frame of nb bits, short frames end in recovery
  task automatic ser(input logic [15:0] f, input int nb, input logic c,
                     output logic [7:0] d);
    int i;
    {mode_o, rd_o} = {1'b0, c};
    cyc(2);
    for (i = 0; i < nb; i++)
    begin
      {wr_o, sd_o} = {1'b0, f[15-i]};
      cyc(2);
      if (i > 7) d[15-i] = three_i ? sdo_i : sdio_i;
      wr_o = 1'b1;
      cyc(2);
    end
    rec_o = (nb < 16);
    cyc(2);
    rec_o = 1'b0;
    if (nb == 16) {rd_o, sd_o} = {1'b1, ~sd_o};
    cyc(2);
  endtask : ser
endmodule : dhc_host_model

// *** tb/dhc_host_port_asserts.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// watches the port pins of the host port
module dhc_host_port_asserts (
  // clock and resets
  input wire logic               clk_sys_i,
  input wire logic               reset_n_i,
  input wire logic               hw_reset_i,
  // host pins
  input wire logic               port_mode_select_i,
  input wire logic               serial_3wire_i,
  input wire logic               rd_n_cs_n_i,
  input wire logic               port_recovery_input_i,
  // device pins
  input wire logic               parallel_data_lines_oe_o,
  input wire logic               serial_data_oe_o,
  input wire logic               serial_out_pin_oe_o,
  input wire logic               sync_clock_out_o,
  input wire dhc_pkg::dhc_prof_t profile_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i || hw_reset_i);
  // serial pins quiet
  wire ser_off = !serial_data_oe_o && !serial_out_pin_oe_o;
  a_sync_period: assert property ($rose(sync_clock_out_o) |-> ##8
    $rose(sync_clock_out_o)) else $error("sync period wrong");
  a_sync_duty: assert property ($rose(sync_clock_out_o) |->
    sync_clock_out_o[*4] ##1 !sync_clock_out_o) else $error("sync duty wrong");
  a_par_serial_off: assert property (!port_mode_select_i |=>
    !parallel_data_lines_oe_o) else $error("bus driven in serial mode");
  a_par_read_on: assert property (port_mode_select_i && !rd_n_cs_n_i |=>
    parallel_data_lines_oe_o) else $error("read not driven");
  a_par_read_off: assert property (port_mode_select_i && rd_n_cs_n_i |=>
    !parallel_data_lines_oe_o) else $error("bus driven without read");
  a_two_wire_out: assert property (!serial_3wire_i |=>
    !serial_out_pin_oe_o) else $error("out pin used in two wire");
  a_three_wire_in: assert property (serial_3wire_i |=>
    !serial_data_oe_o) else $error("data pin driven in three wire");
  a_cs_quiet: assert property (!port_mode_select_i && rd_n_cs_n_i |-> ##2
    ser_off) else $error("serial driven while deselected");
  a_recover_idle: assert property (port_recovery_input_i |-> ##2
    ser_off) else $error("serial driven after recovery");
  a_prof_on_tick: assert property ($changed(profile_o) |->
    $past(sync_clock_out_o) && !$past(sync_clock_out_o, 2))
    else $error("profile changed off tick");
  c_par_read: cover property (parallel_data_lines_oe_o);
  c_out_pin: cover property (serial_out_pin_oe_o);
  c_data_pin: cover property (serial_data_oe_o);
  c_prof: cover property ($changed(profile_o));
endmodule : dhc_host_port_asserts

bind dhc_host_port dhc_host_port_asserts u_dhc_host_port_asserts (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .hw_reset_i(hw_reset_i),
  .port_mode_select_i(port_mode_select_i), .serial_3wire_i(serial_3wire_i),
  .rd_n_cs_n_i(rd_n_cs_n_i), .port_recovery_input_i(port_recovery_input_i),
  .parallel_data_lines_oe_o(parallel_data_lines_oe_o),
  .serial_data_oe_o(serial_data_oe_o), .serial_out_pin_oe_o(serial_out_pin_oe_o),
  .sync_clock_out_o(sync_clock_out_o), .profile_o(profile_o));

// *** tb/dhc_host_port_tb_top.sv ***
`timescale 1ns/1ps
module dhc_host_port_tb_top;
  import dhc_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // stimulus, wires and counters
  logic       clk_sys_i;
  logic       reset_n_i;
  logic       hw_reset_i;
  logic       three;
  logic       upd;
  logic [1:0] ps;
  logic       mode, wr, rd, rec, sd, pd_oe, sd_d, sd_oe, op, op_oe, sync;
  logic [5:0] addr;
  logic [7:0] dat, pd;
  dhc_prof_t  prof;
  wire        sdio = sd_oe ? sd_d : sd;
  // released out pin shows the inverse of its last bit
  wire        sout = op_oe ? op : ~op;
  int         num_errors = 0;
  int         comparisons = 0;
  int         seed = 57;
  int         cycles = 0;
  initial
  begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  // cut a hang short
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      $display("MISMATCH %0t timeout", $time);
      num_errors++;
      final_report();
    end
  end
  dhc_host_port u_dhc_host_port (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .hw_reset_i(hw_reset_i),
    .port_mode_select_i(mode), .serial_3wire_i(three), .wr_n_sclk_i(wr),
    .rd_n_cs_n_i(rd), .register_select_lines_i(addr), .parallel_data_lines_i(dat),
    .parallel_data_lines_o(pd), .parallel_data_lines_oe_o(pd_oe),
    .port_recovery_input_i(rec), .serial_data_i(sdio), .serial_data_o(sd_d),
    .serial_data_oe_o(sd_oe), .serial_out_pin_o(op), .serial_out_pin_oe_o(op_oe),
    .profile_select_inputs_i(ps), .update_strobe_i(upd), .sync_clock_out_o(sync),
    .profile_o(prof));
  dhc_host_model u_dhc_host_model (
    .clk_sys_i(clk_sys_i), .three_i(three), .mode_o(mode), .wr_o(wr), .rd_o(rd),
    .rec_o(rec), .sd_o(sd), .addr_o(addr), .dat_o(dat), .pd_i(pd),
    .pd_oe_i(pd_oe), .sdo_i(sout), .sdio_i(sdio));
  ////////////////////////////////////////////////////////////////////////////
  // expectations and comparisons
  function automatic dhc_prof_t ep(input logic [31:0] t, input logic [15:0] p);
    return {t, p[PH_W-1:0]};
  endfunction : ep
  function automatic logic [5:0] pa(input int p, input int k);
    return 6'(PROF_BASE + PROF_STRIDE * p + k);
  endfunction : pa
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) $display("MISMATCH %0t byte %h exp %h", $time, g, e);
    if (g !== e) num_errors++;
  endtask : chk8
  task automatic chkp(input dhc_prof_t g, input dhc_prof_t e);
    comparisons++;
    if (g !== e) $display("MISMATCH %0t profile %h exp %h", $time, g, e);
    if (g !== e) num_errors++;
  endtask : chkp
  task automatic chkn(input int g, input int e);
    comparisons++;
    if (g != e) $display("MISMATCH %0t count %0d exp %0d", $time, g, e);
    if (g != e) num_errors++;
  endtask : chkn
  // update strobe raised past the edge
  task automatic pulse_update(input logic [1:0] p);
    upd = 1'b0;
    u_dhc_host_model.cyc(10);
    {ps, upd} = {p, 1'b1};
    u_dhc_host_model.cyc(20);
    upd = 1'b0;
  endtask : pulse_update
  task automatic final_report();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    logic [31:0] tw [4];
    logic [15:0] ph [4];
    logic [47:0] v;
    logic [7:0]  b, r;
    dhc_prof_t   last;
    int          p, k, w, n;
    logic        s0;
    reset_n_i  = 1'b0;
    hw_reset_i = 1'b0;
    three      = 1'b0;
    upd        = 1'b0;
    ps         = 2'h0;
    last = '0;
    u_dhc_host_model.cyc(8);
    reset_n_i = 1'b1;
    u_dhc_host_model.cyc(2);
    chkp(prof, last);
    for (p = 0; p < 4; p++)
    begin
      tw[p] = $random(seed);
      ph[p] = $random(seed);
      v = {ph[p], tw[p]};
      for (k = 0; k < 6; k++)
        u_dhc_host_model.pwr(pa(p, k), v[8*k+:8]);
      chkp(prof, last);
      pulse_update(p[1:0]);
      last = ep(tw[p], ph[p]);
      chkp(prof, last);
    end
    for (p = 0; p < 4; p++)
    begin
      ps = p[1:0];
      u_dhc_host_model.cyc(10);
      chkp(prof, ep(tw[p], ph[p]));
    end
    u_dhc_host_model.prd(pa(3, 0), r);
    chk8(r, tw[3][7:0]);
    $display("profile test done");
    for (w = 0; w < 2; w++)
    begin
      three = w[0];
      b = $random(seed);
      u_dhc_host_model.ser({8'h02, b}, 16, 1'b0, r);
      u_dhc_host_model.ser({8'h02, ~b}, 16, 1'b1, r);
      u_dhc_host_model.ser({8'h02, ~b}, 5, 1'b0, r);
      u_dhc_host_model.ser({8'h82, 8'h00}, 16, 1'b0, r);
      chk8(r, b);
    end
    u_dhc_host_model.prd(pa(3, 0), r);
    chk8(r, tw[3][7:0]);
    $display("serial test done");
    // one sync rise per eight clocks
    n = 0;
    repeat (80)
    begin
      s0 = sync;
      u_dhc_host_model.cyc(1);
      if (sync && !s0) n++;
    end
    chkn(n, 80 / SYNC_DIV);
    $display("sync test done");
    hw_reset_i = 1'b1;
    u_dhc_host_model.cyc(3);
    hw_reset_i = 1'b0;
    u_dhc_host_model.cyc(2);
    chkp(prof, '0);
    u_dhc_host_model.prd(pa(3, 0), r);
    chk8(r, REG_RESET);
    $display("reset test done");
    final_report();
  end
endmodule : dhc_host_port_tb_top
